// ==== inc/alu_pkg.sv ====
// Package with operation codes, widths and constants for the integer unit
package alu_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IMM_W  = 16;
   localparam int unsigned REG_W  = 5;

   typedef enum logic [4:0] {
      op_add_imm_trapping,
      op_add_imm_nontrapping,
      op_set_less_imm_signed,
      op_set_less_imm_unsigned,
      op_logical_and_imm,
      op_logical_or_imm,
      op_logical_xor_imm,
      op_load_upper_imm,
      op_reg_sum_trapping,
      op_reg_sum_nontrapping,
      op_reg_diff_trapping,
      op_reg_diff_nontrapping,
      op_set_less_reg_signed,
      op_set_less_reg_unsigned,
      op_reg_and,
      op_reg_or,
      op_reg_xor,
      op_reg_nor
   } alu_op_e;

   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [IMM_W-1:0]  ZERO_HALF = 16'h0000;
endpackage

// ==== design/alu_adder.sv ====
// Shared 32-bit add/subtract with two's complement overflow and compare flags
module alu_adder (
   input  wire logic [31:0] a,
   input  wire logic [31:0] b,
   input  wire logic        sub,
   output logic      [31:0] sum,
   output logic             ovf,
   output logic             lt_signed,
   output logic             lt_unsigned
);
   wire logic [31:0] b_eff;
   wire logic [32:0] full;

   assign b_eff       = sub ? ~b : b;
   assign full        = {1'b0, a} + {1'b0, b_eff} + {32'h0000_0000, sub};
   assign sum         = full[31:0];
   assign ovf         = (a[31] == b_eff[31]) && (sum[31] != a[31]);
   assign lt_unsigned = ~full[32];
   assign lt_signed   = sum[31] ^ ovf;
endmodule // alu_adder

// ==== design/int_alu.sv ====
// Integer unit for immediate and register-register arithmetic and logic
module int_alu (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  op_valid,
   input  wire alu_pkg::alu_op_e      op_code,
   input  wire logic [31:0]           first_source_reg,
   input  wire logic [31:0]           second_source_or_target_reg,
   input  wire logic [15:0]           imm,
   input  wire logic [4:0]            dest_idx,
   output logic      [31:0]           result_q,
   output logic      [4:0]            wr_idx_q,
   output logic                       wr_en_q,
   output logic                       ovf_trap_q
);
   wire logic [31:0] imm_sext;
   wire logic [31:0] imm_zext;
   wire logic [31:0] imm_upper;
   wire logic        is_imm;
   wire logic [31:0] opnd_b;
   wire logic        is_sub;
   wire logic [31:0] sum;
   wire logic        ovf;
   wire logic        lt_s;
   wire logic        lt_u;
   wire logic        trapping;
   wire logic        trap_now;
   logic      [31:0] result_d;

   // Operand form selection
   assign is_imm    = (op_code inside {alu_pkg::op_add_imm_trapping, alu_pkg::op_add_imm_nontrapping,
                       alu_pkg::op_set_less_imm_signed, alu_pkg::op_set_less_imm_unsigned,
                       alu_pkg::op_logical_and_imm, alu_pkg::op_logical_or_imm,
                       alu_pkg::op_logical_xor_imm, alu_pkg::op_load_upper_imm});
   assign imm_sext  = {{alu_pkg::IMM_W{imm[15]}}, imm};
   assign imm_zext  = {alu_pkg::ZERO_HALF, imm};
   assign imm_upper = {imm, alu_pkg::ZERO_HALF};
   assign opnd_b    = is_imm ? imm_sext : second_source_or_target_reg;

   // Subtract path for differences and all compares
   assign is_sub    = (op_code inside {alu_pkg::op_reg_diff_trapping, alu_pkg::op_reg_diff_nontrapping,
                       alu_pkg::op_set_less_imm_signed, alu_pkg::op_set_less_imm_unsigned,
                       alu_pkg::op_set_less_reg_signed, alu_pkg::op_set_less_reg_unsigned});

   alu_adder u_adder (
      .a           (first_source_reg),
      .b           (opnd_b),
      .sub         (is_sub),
      .sum         (sum),
      .ovf         (ovf),
      .lt_signed   (lt_s),
      .lt_unsigned (lt_u)
   );

   // Only the trapping variants can raise overflow
   assign trapping = (op_code inside {alu_pkg::op_add_imm_trapping, alu_pkg::op_reg_sum_trapping,
                      alu_pkg::op_reg_diff_trapping});
   assign trap_now = op_valid && trapping && ovf;

   always_comb begin
      result_d = alu_pkg::ZERO_WORD;
      unique case (op_code)
         alu_pkg::op_add_imm_trapping,
         alu_pkg::op_add_imm_nontrapping:   result_d = sum;
         alu_pkg::op_reg_sum_trapping,
         alu_pkg::op_reg_sum_nontrapping:   result_d = sum;
         alu_pkg::op_reg_diff_trapping,
         alu_pkg::op_reg_diff_nontrapping:  result_d = sum;
         alu_pkg::op_set_less_imm_signed:   result_d = {31'h0000_0000, lt_s};
         alu_pkg::op_set_less_imm_unsigned: result_d = {31'h0000_0000, lt_u};
         alu_pkg::op_set_less_reg_signed:   result_d = {31'h0000_0000, lt_s};
         alu_pkg::op_set_less_reg_unsigned: result_d = {31'h0000_0000, lt_u};
         alu_pkg::op_logical_and_imm:       result_d = first_source_reg & imm_zext;
         alu_pkg::op_logical_or_imm:        result_d = first_source_reg | imm_zext;
         alu_pkg::op_logical_xor_imm:       result_d = first_source_reg ^ imm_zext;
         alu_pkg::op_load_upper_imm:        result_d = imm_upper;
         alu_pkg::op_reg_and:               result_d = first_source_reg & second_source_or_target_reg;
         alu_pkg::op_reg_or:                result_d = first_source_reg | second_source_or_target_reg;
         alu_pkg::op_reg_xor:               result_d = first_source_reg ^ second_source_or_target_reg;
         alu_pkg::op_reg_nor:               result_d = ~(first_source_reg | second_source_or_target_reg);
         default:                           result_d = alu_pkg::ZERO_WORD;
      endcase
   end

   // Writeback stage
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         result_q   <= alu_pkg::ZERO_WORD;
         wr_idx_q   <= 5'h00;
         wr_en_q    <= 1'b0;
         ovf_trap_q <= 1'b0;
      end else begin
         result_q   <= result_d;
         wr_idx_q   <= dest_idx;
         wr_en_q    <= op_valid && !trap_now;
         ovf_trap_q <= trap_now;
      end
   end

   // Checks
   // Reference values built apart from the shared adder
   wire logic [31:0] chk_sext;
   wire logic [31:0] chk_zext;
   wire logic [31:0] chk_imm_sum;
   wire logic [31:0] chk_sum;
   wire logic [31:0] chk_diff;
   wire logic        chk_imm_ovf;
   wire logic        chk_sum_ovf;
   wire logic        chk_diff_ovf;
   wire logic        chk_trap_op;
   wire logic        chk_set_op;

   assign chk_sext     = {{alu_pkg::IMM_W{imm[alu_pkg::IMM_W-1]}}, imm};
   assign chk_zext     = {alu_pkg::ZERO_HALF, imm};
   assign chk_imm_sum  = first_source_reg + chk_sext;
   assign chk_sum      = first_source_reg + second_source_or_target_reg;
   assign chk_diff     = first_source_reg - second_source_or_target_reg;
   assign chk_imm_ovf  = (first_source_reg[31] == chk_sext[31]) && (chk_imm_sum[31] != first_source_reg[31]);
   assign chk_sum_ovf  = (first_source_reg[31] == second_source_or_target_reg[31])
                         && (chk_sum[31] != first_source_reg[31]);
   assign chk_diff_ovf = (first_source_reg[31] != second_source_or_target_reg[31])
                         && (chk_diff[31] != first_source_reg[31]);
   assign chk_trap_op  = (op_code == alu_pkg::op_add_imm_trapping) || (op_code == alu_pkg::op_reg_sum_trapping)
                         || (op_code == alu_pkg::op_reg_diff_trapping);
   assign chk_set_op   = (op_code == alu_pkg::op_set_less_reg_signed)
                         || (op_code == alu_pkg::op_set_less_reg_unsigned);

   // Write strobe and index
   trap_no_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      ovf_trap_q |->
      !wr_en_q)
      else $error("write not suppressed on overflow");

   idle_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
      !op_valid |=>
      !wr_en_q && !ovf_trap_q)
      else $error("strobe without operation");

   write_index_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid |=>
      wr_idx_q == $past(dest_idx))
      else $error("write index wrong");

   // Arithmetic and overflow
   add_sum_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_sum_nontrapping |=>
      result_q == $past(chk_sum) && wr_en_q)
      else $error("register sum wrong");

   sum_plain_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_sum_trapping && !chk_sum_ovf |=>
      result_q == $past(chk_sum) && wr_en_q && !ovf_trap_q)
      else $error("trapping register sum wrong");

   add_trap_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_sum_trapping && chk_sum_ovf |=>
      ovf_trap_q && !wr_en_q)
      else $error("missed add overflow");

   sum_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_sum_nontrapping && chk_sum_ovf |=>
      !ovf_trap_q && wr_en_q)
      else $error("trap on wrapping sum");

   diff_value_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_diff_nontrapping |=>
      result_q == $past(chk_diff) && wr_en_q)
      else $error("register difference wrong");

   diff_plain_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_diff_trapping && !chk_diff_ovf |=>
      result_q == $past(chk_diff) && wr_en_q && !ovf_trap_q)
      else $error("trapping register difference wrong");

   diff_trap_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_diff_trapping && chk_diff_ovf |=>
      ovf_trap_q && !wr_en_q)
      else $error("missed subtract overflow");

   diff_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_diff_nontrapping && chk_diff_ovf |=>
      !ovf_trap_q && wr_en_q)
      else $error("trap on wrapping difference");

   imm_sum_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_add_imm_nontrapping |=>
      result_q == $past(chk_imm_sum) && wr_en_q)
      else $error("add immediate wrong");

   imm_plain_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_add_imm_trapping && !chk_imm_ovf |=>
      result_q == $past(chk_imm_sum) && wr_en_q && !ovf_trap_q)
      else $error("trapping add immediate wrong");

   imm_trap_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_add_imm_trapping && chk_imm_ovf |=>
      ovf_trap_q && !wr_en_q)
      else $error("missed add immediate overflow");

   imm_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_add_imm_nontrapping && chk_imm_ovf |=>
      !ovf_trap_q && wr_en_q)
      else $error("trap on wrapping add immediate");

   nontrap_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
      !chk_trap_op |=>
      !ovf_trap_q)
      else $error("overflow on non-trapping op");

   nontrap_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && !chk_trap_op |=>
      wr_en_q)
      else $error("write missing on non-trapping op");

   // Compares
   imm_lt_signed_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_set_less_imm_signed |=>
      result_q == {31'h0000_0000, $signed($past(first_source_reg)) < $signed($past(chk_sext))})
      else $error("signed immediate compare wrong");

   imm_lt_unsigned_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_set_less_imm_unsigned |=>
      result_q == {31'h0000_0000, $past(first_source_reg) < $past(chk_sext)})
      else $error("unsigned immediate compare wrong");

   imm_lt_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_set_less_imm_unsigned |=>
      !ovf_trap_q && wr_en_q)
      else $error("trap on unsigned immediate compare");

   reg_lt_signed_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_set_less_reg_signed |=>
      result_q == {31'h0000_0000, $signed($past(first_source_reg)) < $signed($past(second_source_or_target_reg))})
      else $error("signed compare wrong");

   reg_lt_unsigned_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_set_less_reg_unsigned |=>
      result_q == {31'h0000_0000, $past(first_source_reg) < $past(second_source_or_target_reg)})
      else $error("unsigned compare wrong");

   set_upper_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && chk_set_op |=>
      result_q[31:1] == 31'h0000_0000 && wr_en_q)
      else $error("compare result upper bits set");

   // Logical and upper immediate
   imm_and_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_logical_and_imm |=>
      result_q == ($past(first_source_reg) & $past(chk_zext)))
      else $error("and immediate wrong");

   imm_or_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_logical_or_imm |=>
      result_q == ($past(first_source_reg) | $past(chk_zext)))
      else $error("or immediate wrong");

   imm_xor_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_logical_xor_imm |=>
      result_q == ($past(first_source_reg) ^ $past(chk_zext)))
      else $error("xor immediate wrong");

   upper_load_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_load_upper_imm |=>
      result_q == {$past(imm), alu_pkg::ZERO_HALF})
      else $error("load upper wrong");

   reg_and_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_and |=>
      result_q == ($past(first_source_reg) & $past(second_source_or_target_reg)))
      else $error("register and wrong");

   reg_or_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_or |=>
      result_q == ($past(first_source_reg) | $past(second_source_or_target_reg)))
      else $error("register or wrong");

   reg_xor_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_xor |=>
      result_q == ($past(first_source_reg) ^ $past(second_source_or_target_reg)))
      else $error("register xor wrong");

   reg_nor_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_nor |=>
      result_q == ~($past(first_source_reg) | $past(second_source_or_target_reg)))
      else $error("register nor wrong");

   trap_seen_c: cover property (@(posedge sys_clk) disable iff (rst) ovf_trap_q);
   set_one_c:   cover property (@(posedge sys_clk) disable iff (rst) wr_en_q && result_q == 32'h0000_0001);
   imm_and_c:   cover property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_logical_and_imm);
   diff_trap_c: cover property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_reg_diff_trapping && chk_diff_ovf);
   imm_wrap_c:  cover property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == alu_pkg::op_add_imm_nontrapping && chk_imm_ovf);
endmodule // int_alu

// ==== sim/regfile_model.sv ====
// Register file and trap counter model fed by the unit's write and trap outputs
module regfile_model (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        wr_en_q,
   input  wire logic [4:0]  wr_idx_q,
   input  wire logic [31:0] result_q,
   input  wire logic        ovf_trap_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [32];
   int          trap_count;
   // Writes land only on the strobe, traps are counted
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trap_count <= 0;
         for (int i = 0; i < 32; i++) mem[i] <= 32'h0000_0000;
      end else begin
         if (wr_en_q) mem[wr_idx_q] <= result_q;
         if (ovf_trap_q) trap_count <= trap_count + 1;
      end
   end
endmodule // regfile_model

// ==== sim/tb.sv ====
// Self-checking bench for the integer unit with corner and random operations
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic             sys_clk = 1'b0;
   logic             rst = 1'b1;
   logic             op_valid = 1'b0;
   alu_pkg::alu_op_e op_code = alu_pkg::op_add_imm_trapping;
   logic [31:0]      first_source_reg = 32'h0000_0000;
   logic [31:0]      second_source_or_target_reg = 32'h0000_0000;
   logic [15:0]      imm = 16'h0000;
   logic [4:0]       dest_idx = 5'h00;
   logic [31:0]      result_q;
   logic [4:0]       wr_idx_q;
   logic             wr_en_q;
   logic             ovf_trap_q;
   logic [31:0]      lfsr_q = 32'h024b_630f;
   logic [31:0]      shadow [32] = '{default: 32'h0000_0000};
   logic [32:0]      exp_q;
   logic [4:0]       exp_idx;
   logic             exp_v = 1'b0;
   int               errors = 0;
   int               checks = 0;
   int               exp_traps = 0;
   always #50 sys_clk = ~sys_clk;
   int_alu DUT (.sys_clk, .rst, .op_valid, .op_code, .first_source_reg, .second_source_or_target_reg, .imm,
                .dest_idx, .result_q, .wr_idx_q, .wr_en_q, .ovf_trap_q);
   regfile_model rf (.sys_clk, .rst, .wr_en_q, .wr_idx_q, .result_q, .ovf_trap_q);
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Returns overflow flag of the trapping ops (0 for all others) above the 32-bit result
   function automatic logic [32:0] expect_op(alu_pkg::alu_op_e op, logic [31:0] a, logic [31:0] b, logic [15:0] im);
      logic [31:0] sx;
      logic [31:0] zx;
      logic [31:0] r;
      logic        ov;
      sx = {{16{im[15]}}, im};
      zx = {16'h0000, im};
      r = 32'h0000_0000;
      ov = 1'b0;
      case (op)
         alu_pkg::op_add_imm_trapping: begin r = a + sx; ov = (a[31] == sx[31]) && (r[31] != a[31]); end
         alu_pkg::op_add_imm_nontrapping: r = a + sx;
         alu_pkg::op_set_less_imm_signed: r[0] = $signed(a) < $signed(sx);
         alu_pkg::op_set_less_imm_unsigned: r[0] = a < sx;
         alu_pkg::op_logical_and_imm: r = a & zx;
         alu_pkg::op_logical_or_imm: r = a | zx;
         alu_pkg::op_logical_xor_imm: r = a ^ zx;
         alu_pkg::op_load_upper_imm: r = {im, 16'h0000};
         alu_pkg::op_reg_sum_trapping: begin r = a + b; ov = (a[31] == b[31]) && (r[31] != a[31]); end
         alu_pkg::op_reg_sum_nontrapping: r = a + b;
         alu_pkg::op_reg_diff_trapping: begin r = a - b; ov = (a[31] != b[31]) && (r[31] != a[31]); end
         alu_pkg::op_reg_diff_nontrapping: r = a - b;
         alu_pkg::op_set_less_reg_signed: r[0] = $signed(a) < $signed(b);
         alu_pkg::op_set_less_reg_unsigned: r[0] = a < b;
         alu_pkg::op_reg_and: r = a & b;
         alu_pkg::op_reg_or: r = a | b;
         alu_pkg::op_reg_xor: r = a ^ b;
         default: r = ~(a | b);
      endcase
      return {ov, r};
   endfunction
   task cmp(string name, logic [36:0] e, logic [36:0] s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, e, s);
      end
   endtask
   // Drives one operation per edge and checks the one driven an edge before
   task step(alu_pkg::alu_op_e op, logic [31:0] a, logic [31:0] b, logic [15:0] im, logic v);
      @(posedge sys_clk);
      op_valid <= v;
      op_code <= op;
      first_source_reg <= a;
      second_source_or_target_reg <= b;
      imm <= im;
      dest_idx <= lfsr_q[4:0];
      #1;
      if (exp_v) cmp("result", {5'h00, exp_q[31:0]}, {5'h00, result_q});
      if (exp_v) cmp("index", {32'h0000_0000, exp_idx}, {32'h0000_0000, wr_idx_q});
      cmp("trap", {36'h0_0000_0000, exp_v & exp_q[32]}, {36'h0_0000_0000, ovf_trap_q});
      cmp("write", {36'h0_0000_0000, exp_v & ~exp_q[32]}, {36'h0_0000_0000, wr_en_q});
      if (exp_v && !exp_q[32]) shadow[exp_idx] = exp_q[31:0];
      if (exp_v && exp_q[32]) exp_traps++;
      exp_v = v;
      exp_q = expect_op(op, a, b, im);
      exp_idx = lfsr_q[4:0];
      lfsr_q = lfsr(lfsr_q);
   endtask
   task end_sim;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #1_000_000;
      errors++;
      end_sim;
   end
   initial begin
      logic [31:0] a;
      logic [31:0] b;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      for (int k = 0; k < 18; k++) begin
         step(alu_pkg::alu_op_e'(k), 32'h7fff_ffff, 32'h0000_0001, 16'h7fff, 1'b1);
         step(alu_pkg::alu_op_e'(k), 32'h8000_0000, 32'h0000_0001, 16'h8000, 1'b1);
         step(alu_pkg::alu_op_e'(k), 32'hffff_ffff, 32'h8000_0000, 16'hffff, 1'b0);
      end
      $display("corner test done");
      repeat (2000) begin
         a = lfsr(lfsr_q);
         b = lfsr(a);
         lfsr_q = lfsr(b);
         step(alu_pkg::alu_op_e'(a[7:0] % 18), a, b, b[31:16] ^ a[15:0], lfsr_q[9]);
      end
      step(alu_pkg::op_reg_or, 32'h0000_0000, 32'h0000_0000, 16'h0000, 1'b0);
      repeat (2) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 32; i++) cmp("register", {5'h00, shadow[i]}, {5'h00, rf.mem[i]});
      cmp("traps", 37'(exp_traps), 37'(rf.trap_count));
      $display("random test done");
      end_sim;
   end
endmodule // tb
